// file: rtl/effa_map.vh
// Constants for the edge flip-flop array: variant and start-up codes.
// Assumes inclusion by bare name from the array's design files.
`ifndef EFFA_MAP_VH
`define EFFA_MAP_VH

// Variant select
`define EFFA_VAR_RISING_D   2'h0
`define EFFA_VAR_FALLING_JK 2'h1
`define EFFA_VAR_DUAL_D     2'h2
`define EFFA_VAR_DUAL_JK    2'h3

// Start-up state select
`define EFFA_INIT_ZERO      2'h0
`define EFFA_INIT_ONE       2'h1
`define EFFA_INIT_UNKNOWN   2'h2

// Default element count
`define EFFA_WIDTH_DEF      1

`endif

// file: rtl/effa_edge.v
// Edge detector for the sampled storage clock of the flip-flop array.
// Assumes the storage clock and enables are synchronous to SYS_CLK.
`default_nettype none

module effa_edge
(
    // System
    input  wire sys_clk,
    input  wire rst_b,
    // Sampled storage clock
    input  wire ff_clk,
    // Edge pulses
    output wire rise,
    output wire fall
);

    reg clk_prev_r;

    // Previous level of the storage clock
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            clk_prev_r <= 1'b0;
        end
        else
        begin
            clk_prev_r <= ff_clk;
        end
    end

    assign rise = ff_clk & ~clk_prev_r;
    assign fall = ~ff_clk & clk_prev_r;

endmodule

`default_nettype wire

// file: rtl/effa_top.v
// Parameterised array of edge-triggered storage elements, four variants.
// Assumes all inputs synchronous to SYS_CLK; storage clock is a sampled level.
//
// Contract
// R1 - Active force-one or zero input overrides state
// R2 - Both forces low drive both outputs high
// R3 - D type loads data on edge, else holds
// R4 - Falling JK: hold, clear, set, toggle
// R5 - Dual D loads only on enabled edges
// R6 - Dual JK: clear, set, otherwise hold
// R7 - Single D rises, single JK falls
// R8 - Forces, clock, enables shared by all elements
// R9 - Elements start unknown unless start option chosen
// R10 - Unknown input makes output unknown only if decisive
// R11 - Element count is a parameter; vector ports
`default_nettype none
`include "effa_map.vh"

module effa_top
#(
    parameter       WIDTH   = `EFFA_WIDTH_DEF,
    parameter [1:0] VARIANT = `EFFA_VAR_RISING_D,
    parameter [1:0] INIT    = `EFFA_INIT_UNKNOWN
)
(
    // System
    input  wire             SYS_CLK,
    input  wire             RST_B,
    // Shared controls
    input  wire             FORCE_ONE_N,
    input  wire             ASYNC_ZERO_N,
    input  wire             FF_CLK,
    input  wire             RISE_EDGE_ENABLE,
    input  wire             FALL_EDGE_ENABLE,
    // Per-element data
    input  wire [WIDTH-1:0] D,
    input  wire [WIDTH-1:0] J,
    input  wire [WIDTH-1:0] K,
    // Per-element unknown markers
    input  wire [WIDTH-1:0] D_UNK,
    input  wire [WIDTH-1:0] J_UNK,
    input  wire [WIDTH-1:0] K_UNK,
    // Outputs
    output wire [WIDTH-1:0] Q,
    output wire [WIDTH-1:0] Q_B,
    output wire [WIDTH-1:0] Q_KNOWN
);

    localparam IS_JK  = (VARIANT == `EFFA_VAR_FALLING_JK) || (VARIANT == `EFFA_VAR_DUAL_JK);
    localparam TOGGLE = (VARIANT == `EFFA_VAR_FALLING_JK);

    // Start-up values chosen by INIT
    localparam [WIDTH-1:0] START_Q = (INIT == `EFFA_INIT_ONE) ? {WIDTH{1'b1}} : {WIDTH{1'b0}};
    localparam [WIDTH-1:0] START_K = (INIT == `EFFA_INIT_UNKNOWN) ? {WIDTH{1'b0}} : {WIDTH{1'b1}};

    reg  [WIDTH-1:0] state_r;
    reg  [WIDTH-1:0] state_nxt;
    reg  [WIDTH-1:0] known_r;
    reg  [WIDTH-1:0] known_nxt;
    reg  [WIDTH-1:0] q_r;
    reg  [WIDTH-1:0] q_nxt;
    reg  [WIDTH-1:0] qb_r;
    reg  [WIDTH-1:0] qb_nxt;
    reg  [WIDTH-1:0] qk_r;
    reg              load;
    reg              unstable;
    reg              res;
    reg              first;
    reg              agree;
    reg              qv;
    reg              jv;
    reg              kv;
    integer          i;
    integer          c;
    wire             rise;
    wire             fall;

    // JK next value; toggle on 11 for single edge, hold for dual edge
    function jk_next;
        input tog;
        input q;
        input j;
        input k;
        begin
            case ({j, k})
                2'h0:    jk_next = q;
                2'h1:    jk_next = 1'b0;
                2'h2:    jk_next = 1'b1;
                2'h3:    jk_next = tog ? ~q : q;
                default: jk_next = q;
            endcase
        end
    endfunction

    effa_edge u_edge
    (
        .sys_clk (SYS_CLK),
        .rst_b   (RST_B),
        .ff_clk  (FF_CLK),
        .rise    (rise),
        .fall    (fall)
    );

    // Load condition per variant, common to every element
    always @*
    begin
        case (VARIANT)
            `EFFA_VAR_RISING_D:   load = rise; // see R7 see R8
            `EFFA_VAR_FALLING_JK: load = fall; // see R7
            `EFFA_VAR_DUAL_D,
            `EFFA_VAR_DUAL_JK:    load = (rise & RISE_EDGE_ENABLE) |
                                         (fall & FALL_EDGE_ENABLE); // see R5 see R6
            default:              load = 1'b0;
        endcase
    end

    // Next state and known flag per element
    always @*
    begin
        state_nxt = state_r;
        known_nxt = known_r;
        unstable  = ~FORCE_ONE_N & ~ASYNC_ZERO_N;
        res       = 1'b0;
        first     = 1'b0;
        agree     = 1'b1;
        qv        = 1'b0;
        jv        = 1'b0;
        kv        = 1'b0;
        i         = 0;
        c         = 0;
        for (i = 0; i < WIDTH; i = i + 1)
        begin
            if (unstable)
            begin
                // Outcome after release is undefined
                state_nxt[i] = 1'b1;
                known_nxt[i] = 1'b0;
            end
            else if (!ASYNC_ZERO_N)
            begin
                state_nxt[i] = 1'b0; // see R1
                known_nxt[i] = 1'b1;
            end
            else if (!FORCE_ONE_N)
            begin
                state_nxt[i] = 1'b1; // see R1
                known_nxt[i] = 1'b1;
            end
            else if (load && !IS_JK)
            begin
                state_nxt[i] = D[i]; // see R3 see R5
                known_nxt[i] = ~D_UNK[i]; // see R10
            end
            else if (load)
            begin
                // Try every value of each unknown input, and of the state when it is unknown
                agree = 1'b1;
                first = 1'b0;
                for (c = 0; c < 8; c = c + 1)
                begin
                    qv  = known_r[i] ? state_r[i] : c[2];
                    jv  = J_UNK[i] ? c[1] : J[i];
                    kv  = K_UNK[i] ? c[0] : K[i];
                    res = jk_next(TOGGLE, qv, jv, kv); // see R4 see R6
                    if (c == 0)
                    begin
                        first = res;
                    end
                    else if (res != first)
                    begin
                        agree = 1'b0; // see R10
                    end
                end
                state_nxt[i] = first;
                known_nxt[i] = agree;
            end
        end
    end

    // Output values; both high while the forces fight
    always @*
    begin
        if (unstable)
        begin
            q_nxt  = {WIDTH{1'b1}}; // see R2
            qb_nxt = {WIDTH{1'b1}}; // see R2
        end
        else
        begin
            q_nxt  = state_nxt; // see R3
            qb_nxt = ~state_nxt; // see R3
        end
    end

    // Storage; start-up value chosen by INIT
    always @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state_r <= START_Q; // see R9
            known_r <= START_K; // see R9
            q_r     <= START_Q;
            qb_r    <= ~START_Q;
            qk_r    <= START_K;
        end
        else
        begin
            state_r <= state_nxt;
            known_r <= known_nxt;
            q_r     <= q_nxt;
            qb_r    <= qb_nxt;
            qk_r    <= known_nxt;
        end
    end

    // Vector outputs, one bit per element
    assign Q       = q_r; // see R11
    assign Q_B     = qb_r;
    assign Q_KNOWN = qk_r;

endmodule

`default_nettype wire

// file: verif/effa_props.sv
// Port checker for the edge flip-flop array.
// Assumes binding to effa_top; JK load rules watched on element 0.
`default_nettype none
module effa_props
#(
    parameter       WIDTH   = 1,
    parameter [1:0] VARIANT = 2'h0
)
(
    // System
    input wire logic             SYS_CLK,
    input wire logic             RST_B,
    // Shared controls
    input wire logic             FORCE_ONE_N,
    input wire logic             ASYNC_ZERO_N,
    input wire logic             FF_CLK,
    // Element inputs
    input wire logic [WIDTH-1:0] J,
    input wire logic [WIDTH-1:0] K,
    input wire logic [WIDTH-1:0] J_UNK,
    input wire logic [WIDTH-1:0] K_UNK,
    // Outputs
    input wire logic [WIDTH-1:0] Q,
    input wire logic [WIDTH-1:0] Q_B,
    input wire logic [WIDTH-1:0] Q_KNOWN
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    wire quiet = FORCE_ONE_N && ASYNC_ZERO_N;
    wire jk    = VARIANT == 2'h1;
    wire kn    = !J_UNK[0] && !K_UNK[0];
    sequence s_fall; quiet && jk && kn && $fell(FF_CLK); endsequence
    sequence s_rise; quiet && jk && $rose(FF_CLK); endsequence
    property p_clr; !ASYNC_ZERO_N && FORCE_ONE_N |=> Q == '0 && Q_B == '1; endproperty
    a_clr: assert property (p_clr) else $error("clear failed");
    property p_set; !FORCE_ONE_N && ASYNC_ZERO_N |=> Q == '1 && Q_B == '0; endproperty
    a_set: assert property (p_set) else $error("set failed");
    property p_both; !FORCE_ONE_N && !ASYNC_ZERO_N |=> Q == '1 && Q_B == '1; endproperty
    a_both: assert property (p_both) else $error("both low failed");
    property p_hold; quiet && $stable(FF_CLK) |=> $stable(Q); endproperty
    a_hold: assert property (p_hold) else $error("state moved");
    property p_jset; s_fall ##0 J[0] && !K[0] |=> Q[0] && Q_KNOWN[0]; endproperty
    a_jset: assert property (p_jset) else $error("jk set failed");
    property p_jclr; s_fall ##0 !J[0] && K[0] |=> !Q[0] && Q_KNOWN[0]; endproperty
    a_jclr: assert property (p_jclr) else $error("jk clear failed");
    property p_jtog; s_fall ##0 J[0] && K[0] && Q_KNOWN[0] |=> Q[0] != $past(Q[0]); endproperty
    a_jtog: assert property (p_jtog) else $error("jk toggle failed");
    property p_rise; s_rise |=> $stable(Q) && $stable(Q_KNOWN); endproperty
    a_rise: assert property (p_rise) else $error("rise acted");
endmodule
bind effa_top effa_props #(.WIDTH(WIDTH), .VARIANT(VARIANT)) u_props (.SYS_CLK(SYS_CLK),
    .RST_B(RST_B), .FORCE_ONE_N(FORCE_ONE_N), .ASYNC_ZERO_N(ASYNC_ZERO_N), .FF_CLK(FF_CLK),
    .J(J), .K(K), .J_UNK(J_UNK), .K_UNK(K_UNK), .Q(Q), .Q_B(Q_B), .Q_KNOWN(Q_KNOWN));
`default_nettype wire

// file: verif/effa_clk_src.sv
// Far-side source of the storage clock: one high sample per request.
// Assumes run is driven at SYS_CLK rising edges.
`default_nettype none
module effa_clk_src
(
    // System
    input  wire logic clk,
    // Request
    input  wire logic run,
    // Storage clock
    output var logic  ff_clk
);
    timeunit 1ns;
    timeprecision 100ps;
    initial ff_clk = 1'h0;
    always @(posedge clk)
    begin
        ff_clk <= run && !ff_clk;
    end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Testbench for the array as a two-element falling-edge JK store.
// Assumes effa_clk_src as storage clock source.
`default_nettype none
`include "effa_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk, rst_b, f1n, zn, run;
    logic [1:0] j, k, ju, ku;
    logic [5:0] msk;
    wire        ffc;
    wire  [1:0] q, qb, qk;
    wire  [5:0] obs = {q, qb, qk};
    int         num_errors, samples_checked;
    effa_clk_src i_src (.clk(clk), .run(run), .ff_clk(ffc));
    effa_top #(.WIDTH(2), .VARIANT(`EFFA_VAR_FALLING_JK)) i_dut (.SYS_CLK(clk),
        .RST_B(rst_b), .FORCE_ONE_N(f1n), .ASYNC_ZERO_N(zn), .FF_CLK(ffc),
        .RISE_EDGE_ENABLE(1'h0), .FALL_EDGE_ENABLE(1'h0), .D(2'h0), .J(j), .K(k),
        .D_UNK(2'h0), .J_UNK(ju), .K_UNK(ku), .Q(q), .Q_B(qb), .Q_KNOWN(qk));
    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    task step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task chk(input logic [5:0] e);
        #1;
        samples_checked++;
        if ((obs & msk) !== e)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, obs & msk, e);
        end
    endtask
    task report_and_stop;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task pulse(input logic [5:0] mid, fin);
        run <= 1'h1;
        step(1);
        run <= 1'h0;
        step(1);
        chk(mid);
        step(1);
        chk(fin);
    endtask
    task t_force;
        step(1); zn <= 1'h0;
        step(1); chk(6'h0f);
        step(1); f1n <= 1'h0; zn <= 1'h1;
        step(1); chk(6'h33);
        step(1); zn <= 1'h0;
        step(1); chk(6'h3c);
        step(1); f1n <= 1'h1; zn <= 1'h1;
        step(1); chk(6'h30);
    endtask
    task t_jk;
        step(1); j <= 2'h1; k <= 2'h2;
        pulse(6'h30, 6'h1b);
        step(1); j <= 2'h0; k <= 2'h1;
        pulse(6'h1b, 6'h0f);
        step(1); j <= 2'h3; k <= 2'h3;
        pulse(6'h0f, 6'h33);
    endtask
    task t_unk;
        step(1); j <= 2'h3; ju <= 2'h3; k <= 2'h1;
        pulse(6'h33, 6'h27);
        step(1); j <= 2'h1; ju <= 2'h0; ku <= 2'h3; k <= 2'h0; msk <= 6'h17;
        pulse(6'h07, 6'h11);
    endtask
    initial
    begin
        f1n = 1'h1; zn = 1'h1; run = 1'h0; j = 2'h0; k = 2'h0; ju = 2'h0; ku = 2'h0;
        msk = 6'h3f; rst_b = 1'h0; num_errors = 0; samples_checked = 0;
        step(12); rst_b <= 1'h1;
        step(1); chk(6'h0c);
        t_force;
        t_jk;
        t_unk;
        report_and_stop;
    end
    initial
    begin
        repeat (2000) @(posedge clk);
        num_errors++;
        report_and_stop;
    end
endmodule
`default_nettype wire
